/* logic/bal_map.vh */
// byte arithmetic/logic unit: register offsets, fields, opcodes, counts
// assumes a 32-bit avalon-mm slave with byte addresses, one word a register
`ifndef BAL_MAP_VH
`define BAL_MAP_VH

// register byte offsets
`define BAL_OFS_DST 8'h00
`define BAL_OFS_SRC 8'h04
`define BAL_OFS_CONST 8'h08
`define BAL_OFS_HIGH 8'h0C
`define BAL_OFS_CMD 8'h10
`define BAL_OFS_FLAGS 8'h14

// status flag positions
`define BAL_F_C 0
`define BAL_F_Z 1
`define BAL_F_N 2
`define BAL_F_V 3
`define BAL_F_S 4
`define BAL_F_H 5
`define BAL_F_BUSY 6
`define BAL_F_ERR 7

// flag update masks
`define BAL_M_ZCNVH 6'h2F
`define BAL_M_ZCNVS 6'h1F
`define BAL_M_ZCNV 6'h0F
`define BAL_M_ZNV 6'h0E

// command register fields
`define BAL_CMD_OP_MSB 4
`define BAL_CMD_CONST_BIT 5

// operation codes
`define BAL_OP_ADD 5'h00
`define BAL_OP_ADD_CARRY 5'h01
`define BAL_OP_WORD_CONSTANT_SUM 5'h02
`define BAL_OP_DIFFERENCE 5'h03
`define BAL_OP_BORROW_DIFFERENCE 5'h04
`define BAL_OP_WORD_CONSTANT_DIFFERENCE 5'h05
`define BAL_OP_CONJUNCTION 5'h06
`define BAL_OP_DISJUNCTION 5'h07
`define BAL_OP_EXCLUSIVE_DISJUNCTION 5'h08
`define BAL_OP_INVERT_ALL_BITS 5'h09
`define BAL_OP_ZERO_MINUS_OPERAND 5'h0A
`define BAL_OP_SET_BITS_BY_MASK 5'h0B
`define BAL_OP_CLEAR_BITS_BY_MASK 5'h0C
`define BAL_OP_INCREMENT 5'h0D
`define BAL_OP_SUBTRACT_ONE 5'h0E
`define BAL_OP_ZERO_SIGN_CHECK 5'h0F
`define BAL_OP_ZERO_REGISTER 5'h10

// reset values and timing
`define BAL_RST_BYTE 8'h00
`define BAL_RST_FLAGS 6'h00
`define BAL_WORD_CYCLES 2

`endif

/* logic/bal_byte_alu.v */
// byte_arith_logic_unit: combinational 8-bit datapath with flag outputs
// assumes the caller registers result and flags in one clock
`timescale 1ns/1ps
`include "bal_map.vh"

module bal_byte_alu (
    input wire [4:0] op_in,
    input wire [7:0] dst_in,
    input wire [7:0] opnd_in,
    input wire carry_in,
    output reg [7:0] result_out,
    output reg [5:0] flags_out,
    output reg [5:0] update_out
);

reg [7:0] a;
reg [7:0] bx;
reg cin;
reg inv;
reg [8:0] sum;
reg [4:0] half;
reg c;
reg h;
reg v;

// one shared adder; subtraction adds the inverted operand
always @*
begin
    a = dst_in;
    bx = opnd_in;
    cin = 1'b0;
    inv = 1'b0;
    update_out = `BAL_M_ZNV;
    case (op_in)
        `BAL_OP_ADD_CARRY: cin = carry_in;
        `BAL_OP_DIFFERENCE:
        begin
            bx = ~opnd_in;
            cin = 1'b1;
            inv = 1'b1;
        end
        `BAL_OP_BORROW_DIFFERENCE:
        begin
            bx = ~opnd_in;
            cin = ~carry_in;
            inv = 1'b1;
        end
        `BAL_OP_ZERO_MINUS_OPERAND:
        begin
            a = 8'h00;
            bx = ~dst_in;
            cin = 1'b1;
            inv = 1'b1;
        end
        `BAL_OP_INCREMENT: bx = 8'h01;
        `BAL_OP_SUBTRACT_ONE:
        begin
            bx = 8'hFE;
            cin = 1'b1;
            inv = 1'b1;
        end
        default: cin = 1'b0;
    endcase
    sum = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
    half = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
    c = sum[8] ^ inv; // borrow is the missing carry
    h = half[4] ^ inv;
    v = (a[7] == bx[7]) && (sum[7] != a[7]);
    result_out = sum[7:0];
    case (op_in)
        `BAL_OP_ADD, `BAL_OP_ADD_CARRY, `BAL_OP_DIFFERENCE,
        `BAL_OP_BORROW_DIFFERENCE, `BAL_OP_ZERO_MINUS_OPERAND:
            update_out = `BAL_M_ZCNVH;
        `BAL_OP_CONJUNCTION, `BAL_OP_ZERO_SIGN_CHECK:
            result_out = dst_in & opnd_in;
        `BAL_OP_DISJUNCTION, `BAL_OP_SET_BITS_BY_MASK:
            result_out = dst_in | opnd_in;
        `BAL_OP_EXCLUSIVE_DISJUNCTION, `BAL_OP_ZERO_REGISTER:
            result_out = dst_in ^ opnd_in;
        `BAL_OP_CLEAR_BITS_BY_MASK:
            result_out = dst_in & (8'hFF - opnd_in);
        `BAL_OP_INVERT_ALL_BITS:
        begin
            result_out = 8'hFF - dst_in;
            c = 1'b1; // complement always sets carry
            update_out = `BAL_M_ZCNV;
        end
        default: result_out = sum[7:0];
    endcase
    // logic results never overflow
    if ((update_out != `BAL_M_ZCNVH) && (op_in != `BAL_OP_INCREMENT) &&
        (op_in != `BAL_OP_SUBTRACT_ONE))
        v = 1'b0;
    flags_out = {h, result_out[7] ^ v, v, result_out[7],
                 result_out == 8'h00, c};
end

endmodule // bal_byte_alu

/* logic/bal_word_unit.v */
// byte_arith_logic_unit: 16-bit pair plus/minus constant over two clocks
// assumes low, high, constant and direction stay put until done
`timescale 1ns/1ps
`include "bal_map.vh"

module bal_word_unit (
    input wire clk_in,
    input wire rst_in,
    input wire start_in,
    input wire sub_in,
    input wire [7:0] low_in,
    input wire [7:0] high_in,
    input wire [7:0] k_in,
    output reg done_out,
    output reg [7:0] low_out,
    output reg [7:0] high_out,
    output reg [5:0] flags_out
);

reg phase_q;
reg carry_q;
wire [8:0] lo_sum;
wire [8:0] hi_sum;
wire [15:0] res;
wire v;
wire c;

// low byte first, its carry or borrow feeds the high byte
assign lo_sum = sub_in ? {1'b0, low_in} - {1'b0, k_in}
                       : {1'b0, low_in} + {1'b0, k_in};
assign hi_sum = sub_in ? {1'b0, high_in} - {8'h00, carry_q}
                       : {1'b0, high_in} + {8'h00, carry_q};
assign res = {hi_sum[7:0], low_out};
assign v = sub_in ? (high_in[7] & ~res[15]) : (~high_in[7] & res[15]);
assign c = sub_in ? (res[15] & ~high_in[7]) : (~res[15] & high_in[7]);

// two-phase sequence, one byte a clock
always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        phase_q <= 1'b0;
        carry_q <= 1'b0;
        done_out <= 1'b0;
        low_out <= `BAL_RST_BYTE;
        high_out <= `BAL_RST_BYTE;
        flags_out <= `BAL_RST_FLAGS;
    end
    else
    begin
        done_out <= phase_q;
        if (start_in && !phase_q)
        begin
            low_out <= lo_sum[7:0];
            carry_q <= lo_sum[8];
            phase_q <= 1'b1;
        end
        else if (phase_q)
        begin
            high_out <= hi_sum[7:0];
            flags_out <= {1'b0, res[15] ^ v, v, res[15],
                          res == 16'h0000, c};
            phase_q <= 1'b0;
        end
    end
end

endmodule // bal_word_unit

/* logic/bal_unit.v */
// byte_arith_logic_unit top: avalon-mm register slave around the datapath
// assumes one clock, async high reset, a single avalon master
`timescale 1ns/1ps
`include "bal_map.vh"

module bal_unit (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    output reg busy_out,
    output reg done_out
);

// bus and operation sequencer states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_ACK = 3'b010;
localparam [2:0] ST_WORD = 3'b100;

// software-visible registers
reg [7:0] dst_q;
reg [7:0] dst_d;
reg [7:0] src_q;
reg [7:0] src_d;
reg [7:0] const_q;
reg [7:0] const_d;
reg [7:0] high_q;
reg [7:0] high_d;
reg [5:0] cmd_q;
reg [5:0] cmd_d;
reg [5:0] flags_q;
reg [5:0] flags_d;
reg err_q;
reg err_d;

// sequencer and bus answer
reg [2:0] state_q;
reg [2:0] state_d;
reg [31:0] rdata_d;
reg wait_d;
reg done_d;
reg word_start_d;
reg word_start_q;

// datapath connections
wire [4:0] op;
wire use_const;
wire [7:0] opnd;
wire [7:0] alu_res;
wire [5:0] alu_flags;
wire [5:0] alu_upd;
wire word_done;
wire [7:0] word_lo;
wire [7:0] word_hi;
wire [5:0] word_flags;
wire word_sub;
wire lane0;
wire hit_cmd;
wire [4:0] new_op;

// keep the old flag where the operation leaves it alone
function [5:0] merge_flags;
    input [5:0] old_f;
    input [5:0] new_f;
    input [5:0] mask;
    begin
        merge_flags = (old_f & ~mask) | (new_f & mask);
    end
endfunction

// true for opcodes outside the implemented set
function op_illegal;
    input [4:0] code;
    begin
        op_illegal = code > `BAL_OP_ZERO_REGISTER;
    end
endfunction

// true for opcodes handled by the two-clock pair unit
function op_is_word;
    input [4:0] code;
    begin
        op_is_word = (code == `BAL_OP_WORD_CONSTANT_SUM) ||
                     (code == `BAL_OP_WORD_CONSTANT_DIFFERENCE);
    end
endfunction

// command currently in the command register
assign op = cmd_q[`BAL_CMD_OP_MSB:0];
assign use_const = cmd_q[`BAL_CMD_CONST_BIT];
// write data only counts when the low byte lane is enabled
assign lane0 = avs_byteenable_in[0];
assign hit_cmd = avs_write_in && lane0 &&
                 (avs_address_in == `BAL_OFS_CMD);
assign new_op = avs_writedata_in[`BAL_CMD_OP_MSB:0];

// second operand: register or constant, mask ops always use constant
assign opnd = (use_const ||
               op == `BAL_OP_SET_BITS_BY_MASK ||
               op == `BAL_OP_CLEAR_BITS_BY_MASK) ? const_q :
              (op == `BAL_OP_ZERO_SIGN_CHECK ||
               op == `BAL_OP_ZERO_REGISTER) ? dst_q : src_q;
assign word_sub = (op == `BAL_OP_WORD_CONSTANT_DIFFERENCE);

// byte datapath, result lands one clock after the command
bal_byte_alu u_byte (
    .op_in(op),
    .dst_in(dst_q),
    .opnd_in(opnd),
    .carry_in(flags_q[`BAL_F_C]),
    .result_out(alu_res),
    .flags_out(alu_flags),
    .update_out(alu_upd)
);

// pair datapath: low in destination, high in the high register
bal_word_unit u_word (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(word_start_q),
    .sub_in(word_sub),
    .low_in(dst_q),
    .high_in(high_q),
    .k_in(const_q),
    .done_out(word_done),
    .low_out(word_lo),
    .high_out(word_hi),
    .flags_out(word_flags)
);

// read multiplexer, unmapped offsets read zero
always @*
begin
    case (avs_address_in)
        `BAL_OFS_DST: rdata_d = {24'h000000, dst_q};
        `BAL_OFS_SRC: rdata_d = {24'h000000, src_q};
        `BAL_OFS_CONST: rdata_d = {24'h000000, const_q};
        `BAL_OFS_HIGH: rdata_d = {24'h000000, high_q};
        `BAL_OFS_CMD: rdata_d = {26'h0000000, cmd_q};
        `BAL_OFS_FLAGS:
            rdata_d = {24'h000000, err_q, busy_out, flags_q};
        default: rdata_d = 32'h00000000;
    endcase
end

// next-state logic: bus handshake, register writes, execution
always @*
begin
    state_d = state_q;
    dst_d = dst_q;
    src_d = src_q;
    const_d = const_q;
    high_d = high_q;
    cmd_d = cmd_q;
    flags_d = flags_q;
    err_d = err_q;
    wait_d = 1'b1;
    done_d = 1'b0;
    word_start_d = 1'b0;
    case (state_q)
        ST_IDLE:
        begin
            // drop waitrequest one clock after a request appears
            if (avs_read_in || avs_write_in)
            begin
                wait_d = 1'b0;
                state_d = ST_ACK;
            end
        end
        ST_ACK:
        begin
            // the master samples waitrequest low at this edge
            state_d = ST_IDLE;
            if (avs_write_in && lane0)
            begin
                case (avs_address_in)
                    `BAL_OFS_DST: dst_d = avs_writedata_in[7:0];
                    `BAL_OFS_SRC: src_d = avs_writedata_in[7:0];
                    `BAL_OFS_CONST: const_d = avs_writedata_in[7:0];
                    `BAL_OFS_HIGH: high_d = avs_writedata_in[7:0];
                    `BAL_OFS_CMD: cmd_d = avs_writedata_in[5:0];
                    `BAL_OFS_FLAGS: flags_d = avs_writedata_in[5:0];
                    default: cmd_d = cmd_q;
                endcase
            end
            // a command write starts the operation at once
            if (hit_cmd && op_illegal(new_op))
                err_d = 1'b1; // unknown code: only the command register and error bit change
            else if (hit_cmd && op_is_word(new_op))
            begin
                err_d = 1'b0;
                word_start_d = 1'b1;
                state_d = ST_WORD;
            end
            else if (hit_cmd)
            begin
                err_d = 1'b0;
                state_d = ST_WORD; // one more clock to execute
                word_start_d = 1'b0;
            end
        end
        ST_WORD:
        begin
            // bus stays stalled while an operation is in flight
            if (op_is_word(op))
            begin
                if (word_done)
                begin
                    dst_d = word_lo;
                    high_d = word_hi;
                    flags_d = merge_flags(flags_q, word_flags,
                                          `BAL_M_ZCNVS);
                    done_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            else
            begin
                // single-clock byte operation, test keeps its operand
                case (op)
                    `BAL_OP_ADD, `BAL_OP_ADD_CARRY:
                        dst_d = alu_res;
                    `BAL_OP_DIFFERENCE:
                        dst_d = alu_res;
                    `BAL_OP_BORROW_DIFFERENCE:
                        dst_d = alu_res;
                    `BAL_OP_CONJUNCTION:
                        dst_d = alu_res;
                    `BAL_OP_DISJUNCTION:
                        dst_d = alu_res;
                    `BAL_OP_EXCLUSIVE_DISJUNCTION:
                        dst_d = alu_res;
                    `BAL_OP_INVERT_ALL_BITS:
                        dst_d = alu_res;
                    `BAL_OP_SET_BITS_BY_MASK:
                        dst_d = alu_res;
                    `BAL_OP_CLEAR_BITS_BY_MASK:
                        dst_d = alu_res;
                    `BAL_OP_INCREMENT:
                        dst_d = alu_res;
                    `BAL_OP_SUBTRACT_ONE:
                        dst_d = alu_res;
                    `BAL_OP_ZERO_SIGN_CHECK:
                        dst_d = dst_q;
                    `BAL_OP_ZERO_REGISTER:
                        dst_d = alu_res;
                    `BAL_OP_ZERO_MINUS_OPERAND:
                        dst_d = alu_res;
                    default:
                        dst_d = dst_q;
                endcase
                flags_d = merge_flags(flags_q, alu_flags,
                                      alu_upd);
                done_d = 1'b1;
                state_d = ST_IDLE;
            end
        end
        default:
        begin
            state_d = ST_IDLE;
        end
    endcase
end

// the byte datapath covers these through the shared adder and logic:
// carry add borrow forms
// or exclusive or invert
// mask set mask clear zeroing
// negation

// state and register file
always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        state_q <= ST_IDLE;
        dst_q <= `BAL_RST_BYTE;
        src_q <= `BAL_RST_BYTE;
        const_q <= `BAL_RST_BYTE;
        high_q <= `BAL_RST_BYTE;
        cmd_q <= 6'h00;
        flags_q <= `BAL_RST_FLAGS;
        err_q <= 1'b0;
        word_start_q <= 1'b0;
    end
    else
    begin
        state_q <= state_d;
        dst_q <= dst_d;
        src_q <= src_d;
        const_q <= const_d;
        high_q <= high_d;
        cmd_q <= cmd_d;
        flags_q <= flags_d;
        err_q <= err_d;
        word_start_q <= word_start_d;
    end
end

// registered outputs; waitrequest idles high so nothing slips through
always @(posedge clk_in or posedge rst_in)
begin
    if (rst_in)
    begin
        avs_readdata_out <= 32'h00000000;
        avs_waitrequest_out <= 1'b1;
        busy_out <= 1'b0;
        done_out <= 1'b0;
    end
    else
    begin
        avs_waitrequest_out <= wait_d;
        if (state_q == ST_IDLE)
            avs_readdata_out <= rdata_d;
        busy_out <= (state_d == ST_WORD);
        done_out <= done_d;
    end
end

endmodule // bal_unit

/* bench/bal_unit_assertions.sv */
// checker for bal_unit: bus handshake and command timing at the ports
// assumes bal_map.vh on the include path; bound to every bal_unit
`timescale 1ns/1ps
`include "bal_map.vh"

module bal_unit_chk (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire busy_out,
    input wire done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // accepted command write and its opcode
    wire acc = !avs_waitrequest_out;
    wire cmd_acc = avs_write_in && acc && avs_byteenable_in[0]
        && avs_address_in == `BAL_OFS_CMD;
    wire [4:0] opc = avs_writedata_in[4:0];
    wire word_op = opc == `BAL_OP_WORD_CONSTANT_SUM
        || opc == `BAL_OP_WORD_CONSTANT_DIFFERENCE;

    a_wait_single: assert property (acc |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property
        (!(avs_read_in || avs_write_in) |=> avs_waitrequest_out)
        else $error("answer without a request");
    a_byte_timing: assert property (
        cmd_acc && opc <= 5'h10 && !word_op
        |=> (busy_out && !done_out) ##1 (done_out && !busy_out))
        else $error("byte command not done after one cycle");
    a_word_timing: assert property (cmd_acc && word_op
        |=> busy_out [*3] ##1 (done_out && !busy_out))
        else $error("word command timing wrong");
    a_bad_op_idle: assert property (cmd_acc && opc > 5'h10
        |=> (!busy_out && !done_out) [*2])
        else $error("illegal opcode started work");
    a_done_pulse: assert property (done_out |=> !done_out)
        else $error("done longer than one cycle");
    a_busy_stalls: assert property (busy_out |-> avs_waitrequest_out)
        else $error("bus answered while busy");
    a_unmapped_zero: assert property (avs_read_in && acc
        && avs_address_in > 8'h14 |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_flags_idle: assert property (avs_read_in && acc
        && avs_address_in == `BAL_OFS_FLAGS |-> !avs_readdata_out[6])
        else $error("busy bit seen set on a flags read");
endmodule // bal_unit_chk

bind bal_unit bal_unit_chk u_chk (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .busy_out(busy_out),
    .done_out(done_out)
);

/* bench/bal_unit_tb.sv */
// testbench for bal_unit: avalon-mm tasks, operations with expected flags
// assumes bal_map.vh on the include path and the checker bound alongside
`timescale 1ns/1ps
`include "bal_map.vh"

module bal_unit_tb;
    reg clk_in, rst_in, rd_q, wr_q;
    reg [7:0] addr_q, q;
    reg [31:0] wd_q;
    reg [3:0] be_q;
    wire [31:0] rdata;
    wire wreq, busy, done;
    integer fail_count, comparisons, i, dones;

    bal_unit dut (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .avs_address_in(addr_q),
        .avs_read_in(rd_q),
        .avs_write_in(wr_q),
        .avs_writedata_in(wd_q),
        .avs_byteenable_in(be_q),
        .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq),
        .busy_out(busy),
        .done_out(done)
    );

    // 100 MHz clock
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // count finished commands; done must pulse once per legal command
    always @(posedge clk_in)
        if (done === 1'b1)
            dones <= dones + 1;

    task end_of_test;
    begin
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    // one access; held until waitrequest is sampled low, bounded wait
    task bus(input rd, input [7:0] a, input [7:0] d);
        integer n;
    begin
        @(posedge clk_in);
        addr_q <= a;
        wd_q <= {24'h0, d};
        rd_q <= rd;
        wr_q <= ~rd;
        n = 0;
        @(posedge clk_in);
        while (wreq !== 1'b0 && n < 50)
        begin
            n = n + 1;
            @(posedge clk_in);
        end
        chk("answer", 8'h00, {7'h0, n == 50});
        q = rdata[7:0];
        rd_q <= 1'b0;
        wr_q <= 1'b0;
    end
    endtask

    // load operands and flags, run a command, read back all results
    task t(input [5:0] op, input [7:0] d, s, k, input [5:0] f,
        input [7:0] ed, eh, input [5:0] ef);
    begin
        bus(0, `BAL_OFS_DST, d);
        bus(0, `BAL_OFS_SRC, s);
        bus(0, `BAL_OFS_HIGH, s);
        bus(0, `BAL_OFS_CONST, k);
        bus(0, `BAL_OFS_FLAGS, {2'b00, f});
        bus(0, `BAL_OFS_CMD, {2'b00, op});
        bus(1, `BAL_OFS_DST, 8'h00);
        chk("result", ed, q);
        bus(1, `BAL_OFS_HIGH, 8'h00);
        chk("high", eh, q);
        bus(1, `BAL_OFS_FLAGS, 8'h00);
        chk("flags", {2'b00, ef}, q);
    end
    endtask

    // main sequence: reset values, every operation, map corner cases
    initial
    begin
        rst_in = 1'b1;
        rd_q = 1'b0;
        wr_q = 1'b0;
        addr_q = 8'h00;
        wd_q = 32'h0;
        be_q = 4'hF;
        fail_count = 0;
        comparisons = 0;
        dones = 0;
        repeat (10) @(posedge clk_in);
        rst_in <= 1'b0;
        for (i = 0; i < 6; i = i + 1)
            if (i != 4)
            begin
                bus(1, 8'(i * 4), 8'h00);
                chk("reset", 8'h00, q);
            end
        $display("test reset_values done");
        t(6'h00,8'h7F,8'h01,8'h00,6'h10,8'h80,8'h01,6'h3C);
        t(6'h01,8'hFF,8'h00,8'h00,6'h01,8'h00,8'h00,6'h23);
        t(6'h02,8'hFF,8'h7F,8'h01,6'h20,8'h00,8'h80,6'h2C);
        t(6'h23,8'h00,8'h00,8'h01,6'h00,8'hFF,8'h00,6'h25);
        t(6'h03,8'h80,8'h01,8'h00,6'h00,8'h7F,8'h01,6'h28);
        t(6'h04,8'h10,8'h0F,8'h00,6'h01,8'h00,8'h0F,6'h22);
        t(6'h24,8'h00,8'h00,8'h00,6'h01,8'hFF,8'h00,6'h25);
        t(6'h05,8'h00,8'h00,8'h01,6'h00,8'hFF,8'hFF,6'h15);
        t(6'h06,8'hF0,8'h0F,8'h00,6'h09,8'h00,8'h0F,6'h03);
        t(6'h26,8'hCC,8'h00,8'h84,6'h00,8'h84,8'h00,6'h04);
        t(6'h07,8'h80,8'h01,8'h00,6'h00,8'h81,8'h01,6'h04);
        t(6'h27,8'h00,8'h00,8'h00,6'h00,8'h00,8'h00,6'h02);
        t(6'h08,8'hAA,8'hFF,8'h00,6'h08,8'h55,8'hFF,6'h00);
        t(6'h09,8'h0F,8'h00,8'h00,6'h08,8'hF0,8'h00,6'h05);
        t(6'h0A,8'h80,8'h00,8'h00,6'h00,8'h80,8'h00,6'h0D);
        t(6'h0A,8'h01,8'h00,8'h00,6'h00,8'hFF,8'h00,6'h25);
        t(6'h0B,8'h01,8'h02,8'h80,6'h00,8'h81,8'h02,6'h04);
        t(6'h0C,8'hFF,8'h80,8'h81,6'h01,8'h7E,8'h80,6'h01);
        t(6'h0D,8'h7F,8'h00,8'h00,6'h01,8'h80,8'h00,6'h0D);
        t(6'h0D,8'hFF,8'h00,8'h00,6'h00,8'h00,8'h00,6'h02);
        t(6'h0E,8'h80,8'h00,8'h00,6'h01,8'h7F,8'h00,6'h09);
        t(6'h0E,8'h00,8'h00,8'h00,6'h00,8'hFF,8'h00,6'h04);
        t(6'h0F,8'h80,8'h00,8'h00,6'h08,8'h80,8'h00,6'h04);
        t(6'h10,8'h5A,8'h00,8'h00,6'h04,8'h00,8'h00,6'h02);
        $display("test operations done");
        // illegal opcode sets the error bit, next legal command clears it
        bus(0, `BAL_OFS_FLAGS, 8'h00);
        bus(0, `BAL_OFS_CMD, 8'h11);
        bus(1, `BAL_OFS_FLAGS, 8'h00);
        chk("err", 8'h80, q);
        bus(0, `BAL_OFS_CMD, 8'h10);
        bus(1, `BAL_OFS_FLAGS, 8'h00);
        chk("err_clr", 8'h02, q);
        // masked write and unmapped place are answered but change nothing
        be_q <= 4'h0;
        bus(0, `BAL_OFS_DST, 8'h55);
        be_q <= 4'hF;
        bus(1, `BAL_OFS_DST, 8'h00);
        chk("byteen", 8'h00, q);
        bus(0, 8'h18, 8'hAA);
        bus(1, 8'h18, 8'h00);
        chk("unmapped", 8'h00, q);
        chk("done_count", 8'h19, dones[7:0]);
        $display("test map done");
        end_of_test;
    end

    // watchdog: the whole run needs under a thousand cycles
    initial
    begin
        #100000;
        fail_count = fail_count + 1;
        $display("MISMATCH watchdog expected finish seen hang");
        end_of_test;
    end
endmodule // bal_unit_tb
